// File: bench/periph_model.sv
// peripheral on chip select four: acknowledges and returns data
// assumes the bus clock is sampled in the clk_sys domain
`timescale 1ns/10ps
`default_nettype none
module periph_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] dly,
  input wire logic bus_reference_clock,
  input wire logic [31:0] bus_addr,
  input wire logic transfer_start_n,
  input wire logic [7:0] chip_select_n,
  input wire logic output_enable_n,
  output logic [31:0] bus_data_in,
  output logic transfer_acknowledge_n
);
  logic bclk_q;
  logic [1:0] cnt_q;
  logic [31:0] last_q;
  // read data is the inverted address; a released bus toggles each cycle
  assign bus_data_in = output_enable_n ? ~last_q : ~bus_addr;
  // ack moves at bus clock falls, low one period after dly periods
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
      cnt_q <= 2'h0;
      last_q <= 32'h0;
      transfer_acknowledge_n <= 1'b1;
    end else begin
      bclk_q <= bus_reference_clock;
      last_q <= bus_data_in;
      if (bclk_q && !bus_reference_clock) begin
        if (!transfer_acknowledge_n || chip_select_n[4] || !transfer_start_n)
        begin
          transfer_acknowledge_n <= 1'b1;
          cnt_q <= 2'h0;
        end else if (cnt_q == dly) begin
          transfer_acknowledge_n <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/sync_bus_monitor.sv
// pin-level checks of the bus master
// assumes binding into sync_bus_chip_select, one clock, low async reset
`timescale 1ns/10ps
`default_nettype none
`include "sync_bus_regs.svh"
module sync_bus_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`DIV_W-1:0] clk_div,
  input wire logic bus_reference_clock,
  input wire logic transfer_start_n,
  input wire logic [1:0] transfer_width,
  input wire logic read_not_write,
  input wire logic bus_data_oe,
  input wire logic cycle_in_progress_n,
  input wire logic transfer_acknowledge_n,
  input wire logic [`NUM_CS-1:0] chip_select_n,
  input wire logic output_enable_n,
  input wire logic [3:0] byte_write_strobe_n
);
  logic bclk_q;
  logic [9:0] half_q;
  logic [9:0] ts_q;
  // edges since the bus clock moved, and edges with start low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
      half_q <= 10'h000;
      ts_q <= 10'h000;
    end else begin
      bclk_q <= bus_reference_clock;
      half_q <= (bus_reference_clock != bclk_q) ? 10'h001 : half_q + 10'h001;
      ts_q <= transfer_start_n ? 10'h000 : ts_q + 10'h001;
    end
  end
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_BCLK_HALF: assert property (
    bus_reference_clock != bclk_q |-> half_q == {2'h0, clk_div} + 10'h001)
    else $error("bus clock half period wrong");
  AST_TS_ONE_PERIOD: assert property (
    $rose(transfer_start_n) |-> ts_q == {1'h0, clk_div, 1'h0} + 10'h002)
    else $error("start strobe length wrong");
  AST_CS_IN_TIP: assert property (
    (!transfer_start_n || chip_select_n != 8'hFF) |-> !cycle_in_progress_n
    && $onehot0(~chip_select_n)) else $error("select outside cycle");
  AST_OE_READ: assert property (
    !output_enable_n |-> read_not_write && &byte_write_strobe_n)
    else $error("output enable on a write");
  AST_WE_WRITE: assert property (
    !(&byte_write_strobe_n) |-> !read_not_write && transfer_start_n)
    else $error("write strobe misplaced");
  AST_MIN_TWO: assert property (
    $fell(cycle_in_progress_n) |=> !cycle_in_progress_n [*3])
    else $error("transaction too short");
  AST_START_AFTER_ACK: assert property (
    $fell(transfer_start_n) |-> transfer_acknowledge_n)
    else $error("start while acknowledge low");
  AST_BURST_TIP: assert property (
    $fell(transfer_start_n) && transfer_width == `WIDTH_LINE |=>
    !cycle_in_progress_n [*8]) else $error("burst cycle broken");
  AST_DATA_DRIVE: assert property (
    bus_data_oe == (!cycle_in_progress_n && !read_not_write))
    else $error("data bus driven outside a write cycle");
  AST_WE_LANES: assert property (
    !(&byte_write_strobe_n) |-> ((transfer_width == `WIDTH_8) ?
    $onehot(~byte_write_strobe_n) : (transfer_width == `WIDTH_16) ?
    (byte_write_strobe_n == 4'h3 || byte_write_strobe_n == 4'hC) :
    (byte_write_strobe_n == 4'h0))) else $error("byte strobes wrong");
  // main scenarios reached
  cover property ($fell(transfer_start_n) && transfer_width == `WIDTH_LINE);
  cover property (!transfer_acknowledge_n && !cycle_in_progress_n);
  cover property (!(&byte_write_strobe_n));
endmodule
bind sync_bus_chip_select sync_bus_monitor u_mon (.*);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench of the bus master with chip selects
// assumes the peripheral model sits on chip select four
`timescale 1ns/10ps
`default_nettype none
`include "sync_bus_regs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import sync_bus_pkg::*;
  typedef struct {logic [31:0] a; logic w; width_code_t wd; logic [1:0] k;
    logic e; logic [7:0] cs;} row_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_line = 1'b0, req_ready, rsp_valid, rsp_error, rsp_last;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, bus_addr;
  logic [31:0] cs0_base = 32'h0, cs0_mask = 32'hFF00_0000, bus_data_in;
  logic [31:0] cs1_base = 32'h1000_0000, cs1_mask = 32'hFFF0_0000;
  logic [31:0] cs_wait_states = 32'h2, cs_space_en = 32'h0002_00FF;
  logic [31:0] bus_data_out, d_seen;
  logic [127:0] req_line_wdata = 128'h0;
  logic [15:0] cs_port_width = 16'h0200;
  logic [7:0] clk_div = 8'h00, cs_valid = 8'h00, io_base = 8'h40;
  logic [7:0] cs_ext_ack = 8'h10, cs_burst_en = 8'h02, cs_seen;
  logic [7:0] cs_write_protect = 8'h01, chip_select_n;
  logic [4:0] sig_seen;
  logic [3:0] byte_write_strobe_n;
  logic [1:0] req_kind = 2'h0, dly = 2'h0, transfer_width, transfer_kind;
  width_code_t req_width = `WIDTH_32;
  logic bus_reference_clock, bus_data_oe, transfer_start_n, read_not_write;
  logic cycle_in_progress_n, transfer_acknowledge_n, output_enable_n;
  int n_errors = 0, comparisons = 0, n_starts = 0, nb, s;
  row_t rows[9] = '{
    '{32'h1000_0010, 1'b0, `WIDTH_32, 2'h3, 1'b0, 8'hFD},
    '{32'h1000_0020, 1'b1, `WIDTH_32, 2'h1, 1'b0, 8'hFD},
    '{32'h0000_0100, 1'b1, `WIDTH_32, 2'h0, 1'b1, 8'hFF},
    '{32'h4040_0002, 1'b0, `WIDTH_16, 2'h1, 1'b0, 8'hEF},
    '{32'h4040_0004, 1'b0, `WIDTH_16, 2'h0, 1'b1, 8'hFF},
    '{32'h4040_0008, 1'b0, `WIDTH_32, 2'h1, 1'b1, 8'hFF},
    '{32'h8000_0000, 1'b0, `WIDTH_8, 2'h2, 1'b1, 8'hFF},
    '{32'h0000_0203, 1'b0, `WIDTH_8, 2'h2, 1'b0, 8'hFE},
    '{32'h4040_0002, 1'b1, `WIDTH_16, 2'h1, 1'b0, 8'hEF}};
  sync_bus_chip_select u_dut (.*);
  periph_model u_periph (.*);
  initial forever #50 clk_sys = ~clk_sys;
  // remember what the last bus cycle showed, sampled just before each edge
  always @(posedge clk_sys) begin
    if (req_valid && req_ready) cs_seen <= 8'hFF;
    else if (chip_select_n != 8'hFF) cs_seen <= chip_select_n;
    if (!transfer_start_n) sig_seen <= {transfer_width, transfer_kind,
      read_not_write};
    if (!(&byte_write_strobe_n)) d_seen <= bus_data_out;
  end
  always @(negedge transfer_start_n) n_starts++;
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one request, then every response up to the last, bounded waits
  task automatic run(input row_t r, input logic ln, output int beats);
    int i;
    beats = 0;
    {req_addr, req_write, req_width, req_kind} = {r.a, r.w, r.wd, r.k};
    req_line = ln;
    req_wdata = ~r.a;
    req_valid = 1'b1;
    for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 400) begin
      n_errors++;
      wrap_up();
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (i = 0; i < 400 && rsp_last !== 1'b1; i++) begin
      if (rsp_valid === 1'b1) begin
        `CHK(rsp_error, r.e)
        if (!r.w && !r.e && (ln || r.wd == `WIDTH_32))
          `CHK(rsp_rdata, ~(r.a + 32'(beats * 4)))
        beats++;
      end
      @(negedge clk_sys);
    end
    `CHK(rsp_error, r.e)
    if (!r.w && !r.e && (ln || r.wd == `WIDTH_32))
      `CHK(rsp_rdata, ~(r.a + 32'(beats * 4)))
    beats++;
    if (i == 400) begin
      n_errors++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    `CHK({transfer_start_n, chip_select_n}, 9'h1FF)
    rst_n = 1'b1;
    run('{32'h2345_6780, 1'b0, `WIDTH_32, 2'h0, 1'b0, 8'hFE}, 1'b0, nb);
    `CHK(cs_seen, 8'hFE)
    cs_valid = 8'h13;
    foreach (rows[j]) begin
      run(rows[j], 1'b0, nb);
      `CHK(cs_seen, rows[j].cs)
      if (!rows[j].e)
        `CHK(sig_seen, {rows[j].wd, rows[j].k, ~rows[j].w})
      if (rows[j].w && !rows[j].e) `CHK(d_seen, ~rows[j].a)
    end
    // line fill with bursts allowed: one start, four beats
    s = n_starts;
    run('{32'h1000_0100, 1'b0, `WIDTH_LINE, 2'h0, 1'b0, 8'hFD}, 1'b1, nb);
    `CHK({nb, n_starts - s}, {32'd4, 32'd1})
    `CHK(sig_seen[4:3], `WIDTH_LINE)
    // same line where bursts are off: four single cycles
    s = n_starts;
    run('{32'h0000_0400, 1'b0, `WIDTH_LINE, 2'h0, 1'b0, 8'hFE}, 1'b1, nb);
    `CHK({nb, n_starts - s}, {32'd4, 32'd4})
    // slow peripheral, then a slower bus clock after a second reset
    dly = 2'h3;
    run(rows[3], 1'b0, nb);
    `CHK(cs_seen, 8'hEF)
    rst_n = 1'b0;
    clk_div = 8'h02;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    run(rows[0], 1'b0, nb);
    `CHK(cs_seen, 8'hFD)
    wrap_up();
  end
endmodule
`default_nettype wire

// File: rtl/sync_bus_chip_select.sv
// synchronous 32-bit bus master with an eight-way chip-select unit
// assumes one clock clk_sys, inputs synchronous to it, the data bus wire
// resolved outside from bus_data_oe
`timescale 1ns/10ps
`default_nettype none
`include "sync_bus_regs.svh"
module sync_bus_chip_select (
  input wire logic clk_sys,
  input wire logic rst_n,
  // user request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire sync_bus_pkg::width_code_t req_width,
  input wire logic [1:0] req_kind,
  input wire logic req_line,
  input wire logic [31:0] req_wdata,
  input wire logic [127:0] req_line_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic rsp_last,
  output logic [31:0] rsp_rdata,
  // configuration
  input wire logic [`DIV_W-1:0] clk_div,
  input wire logic [`NUM_CS-1:0] cs_valid,
  input wire logic [31:0] cs0_base,
  input wire logic [31:0] cs0_mask,
  input wire logic [31:0] cs1_base,
  input wire logic [31:0] cs1_mask,
  input wire logic [7:0] io_base,
  input wire logic [2*`NUM_CS-1:0] cs_port_width,
  input wire logic [`WAIT_W*`NUM_CS-1:0] cs_wait_states,
  input wire logic [`NUM_CS-1:0] cs_ext_ack,
  input wire logic [`NUM_CS-1:0] cs_burst_en,
  input wire logic [`NUM_CS-1:0] cs_write_protect,
  input wire logic [4*`NUM_CS-1:0] cs_space_en,
  // system bus
  output logic bus_reference_clock,
  output logic [31:0] bus_addr,
  input wire logic [31:0] bus_data_in,
  output logic [31:0] bus_data_out,
  output logic bus_data_oe,
  output logic transfer_start_n,
  output logic [1:0] transfer_width,
  output logic read_not_write,
  output logic [1:0] transfer_kind,
  output logic cycle_in_progress_n,
  input wire logic transfer_acknowledge_n,
  output logic [`NUM_CS-1:0] chip_select_n,
  output logic output_enable_n,
  output logic [3:0] byte_write_strobe_n
);
  import sync_bus_pkg::*;

  bus_regs_t s_q;
  bus_regs_t s_d;
  logic rise;
  logic [`NUM_CS-1:0] hit;
  logic any_hit;
  logic [2:0] hit_idx;
  logic refuse;
  logic use_burst;
  logic done;
  logic active;

  // the select index is three bits and the reset constants fix the widths
  if (`NUM_CS > 8 || `NUM_CS <= `IO_FIRST_CS) begin : g_bad_cs
    $error("chip select count out of range");
  end
  if (`WAIT_W != 4 || `DIV_W != 8) begin : g_bad_width
    $error("wait or divisor width out of range");
  end

  // byte lanes, lane 3 is the most significant byte of the data bus
  function automatic logic [3:0] lanes(input width_code_t w,
                                       input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    case (w)
      `WIDTH_8: m = 4'h8 >> a;
      `WIDTH_16: m = a[1] ? 4'h3 : 4'hC;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // size rank, so a transfer wider than the port can be spotted
  function automatic logic [1:0] rank(input width_code_t w);
    logic [1:0] r;
    r = 2'h2;
    case (w)
      `WIDTH_8: r = 2'h0;
      `WIDTH_16: r = 2'h1;
      default: r = 2'h2;
    endcase
    return r;
  endfunction

  // one decoder per chip select
  genvar g;
  generate
    for (g = 0; g < `NUM_CS; g++) begin : g_cs
      if (g == 0) begin : g_boot
        // boot memory reachable before software touches anything
        assign hit[g] = s_q.boot | (cs_valid[g] &
          (((req_addr ^ cs0_base) & cs0_mask) == 32'h0));
      end else if (g == 1) begin : g_free
        assign hit[g] = cs_valid[g] &
          (((req_addr ^ cs1_base) & cs1_mask) == 32'h0);
      end else begin : g_io
        assign hit[g] = cs_valid[g] &
          (req_addr[`IO_BASE_HI:`IO_BASE_LO] == io_base) &
          (req_addr[`IO_BLOCK_HI:`IO_BLOCK_LO] ==
           3'(g - `IO_FIRST_CS));
      end
    end
  endgenerate

  // lowest numbered select wins when windows overlap
  // overlap is not reported, so software must keep windows apart
  always_comb begin
    hit_idx = `RST_CS;
    for (int i = `NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = 3'(i);
      end
    end
  end

  assign any_hit = |hit;
  // bursts are run only on request and where the select allows them
  assign use_burst = req_line & cs_burst_en[hit_idx];
  // unmapped address, wrong space, write protect or too narrow a port
  assign refuse = ~any_hit |
    ~cs_space_en[{hit_idx, 2'h0} + 5'(req_kind)] |
    (req_write & cs_write_protect[hit_idx]) |
    (rank(req_line ? `WIDTH_32 : req_width) >
     rank(cs_port_width[{hit_idx, 1'b0} +: 2]));

  // rising edge of the bus clock, the only moment the bus advances
  assign rise = (s_q.div_cnt == clk_div) & ~s_q.bclk;
  // ready only on a rise tick, so a request is taken in step with the bus
  assign req_ready = rise & (s_q.st == ST_IDLE);
  // data phase ends on external ack or when the wait count runs out
  assign done = s_q.ext ? ~transfer_acknowledge_n
                        : (s_q.waits == `RST_WAIT);

  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rsp_error = 1'b0;
    s_d.rsp_last = 1'b0;
    // square wave, half period of clk_div+1 core cycles
    if (s_q.div_cnt == clk_div) begin
      s_d.div_cnt = `RST_DIV;
      s_d.bclk = ~s_q.bclk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + `DIV_W'(1);
    end
    // boot decode ends once chip select zero is configured
    if (cs_valid[0]) begin
      s_d.boot = 1'b0;
    end
    if (rise) begin
      case (s_q.st)
        ST_IDLE: begin
          if (req_valid) begin
            if (refuse) begin
              // refused at once, no bus cycle is run
              s_d.rsp_valid = 1'b1;
              s_d.rsp_error = 1'b1;
              s_d.rsp_last = 1'b1;
            end else begin
              s_d.st = ST_START;
              s_d.addr = req_addr;
              s_d.write = req_write;
              s_d.kind = req_kind;
              s_d.cs = hit_idx;
              s_d.burst = use_burst;
              s_d.more = req_line;
              s_d.beats = req_line ? `LAST_BEAT : `RST_BEATS;
              s_d.line = req_line ? req_line_wdata
                                  : {96'h0, req_wdata};
              // a disallowed burst becomes four 32-bit singles
              s_d.width = use_burst ? `WIDTH_LINE :
                          (req_line ? `WIDTH_32 : req_width);
              s_d.ext = cs_ext_ack[hit_idx];
            end
          end
        end
        ST_START: begin
          // start strobe lasts exactly one bus clock
          s_d.st = ST_DATA;
          s_d.waits = cs_wait_states[s_q.cs*`WAIT_W +: `WAIT_W];
        end
        ST_DATA: begin
          if (!done) begin
            s_d.waits = s_q.waits - `WAIT_W'(1);
          end else begin
            s_d.rdata = bus_data_in;
            s_d.rsp_valid = 1'b1;
            s_d.rsp_last = (s_q.beats == `RST_BEATS);
            if (s_q.beats != `RST_BEATS) begin
              s_d.beats = s_q.beats - 2'h1;
              s_d.addr = s_q.addr + `BEAT_STEP;
              s_d.line = s_q.line >> `LINE_SHIFT;
              s_d.waits = cs_wait_states[s_q.cs*`WAIT_W +: `WAIT_W];
              // burst beats follow back to back, singles restart
              s_d.st = s_q.burst ? ST_DATA : ST_RECOVER;
            end else begin
              s_d.more = 1'b0;
              s_d.st = ST_RECOVER;
            end
          end
        end
        ST_RECOVER: begin
          // wait for the acknowledge to go back high before any new start
          // internal wait mode waits too, a stale acknowledge must not count
          if (transfer_acknowledge_n) begin
            s_d.st = s_q.more ? ST_START : ST_IDLE;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
  end

  // the whole state, reset to constants
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= ST_IDLE;
      s_q.div_cnt <= `RST_DIV;
      s_q.bclk <= 1'b0;
      s_q.boot <= 1'b1;
      s_q.addr <= `RST_WORD;
      s_q.line <= `RST_LINE;
      s_q.write <= 1'b0;
      s_q.width <= `WIDTH_32;
      s_q.kind <= 2'h0;
      s_q.burst <= 1'b0;
      s_q.more <= 1'b0;
      s_q.beats <= `RST_BEATS;
      s_q.cs <= `RST_CS;
      s_q.waits <= `RST_WAIT;
      s_q.ext <= 1'b0;
      s_q.rdata <= `RST_WORD;
      s_q.rsp_valid <= 1'b0;
      s_q.rsp_error <= 1'b0;
      s_q.rsp_last <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // bus pins decode straight from registered state
  assign active = (s_q.st == ST_START) | (s_q.st == ST_DATA);
  assign bus_reference_clock = s_q.bclk;
  assign bus_addr = s_q.addr;
  assign bus_data_out = s_q.line[31:0];
  assign bus_data_oe = active & s_q.write;
  assign transfer_start_n = ~(s_q.st == ST_START);
  assign transfer_width = s_q.width;
  assign read_not_write = ~s_q.write;
  assign transfer_kind = s_q.kind;
  // held low through all four beats of a burst
  assign cycle_in_progress_n = ~active;
  assign chip_select_n = active ? ~(`NUM_CS'(1) << s_q.cs)
                                : {`NUM_CS{1'b1}};
  assign output_enable_n = ~(active & ~s_q.write);
  // write strobes only in the data phase so data has settled
  assign byte_write_strobe_n = (s_q.st == ST_DATA && s_q.write) ?
    ~lanes(s_q.width, s_q.addr[1:0]) : `LANES_NONE;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_error = s_q.rsp_error;
  assign rsp_last = s_q.rsp_last;
  assign rsp_rdata = s_q.rdata;
endmodule
`default_nettype wire

// File: rtl/sync_bus_pkg.sv
// types for the synchronous bus master with chip selects
// assumes sync_bus_regs.svh is on the include path
`include "sync_bus_regs.svh"
package sync_bus_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA,
                            ST_RECOVER} bus_state_t;
  typedef logic [1:0] width_code_t;
  typedef struct packed {
    bus_state_t st;
    logic [`DIV_W-1:0] div_cnt;
    logic bclk;
    logic boot;
    logic [31:0] addr;
    logic [127:0] line;
    logic write;
    width_code_t width;
    logic [1:0] kind;
    logic burst;
    logic more;
    logic [1:0] beats;
    logic [2:0] cs;
    logic [`WAIT_W-1:0] waits;
    logic ext;
    logic [31:0] rdata;
    logic rsp_valid;
    logic rsp_error;
    logic rsp_last;
  } bus_regs_t;
endpackage

// File: rtl/sync_bus_regs.svh
// named constants for the synchronous bus master with chip selects
// assumes it is included by its bare name from package and module files
`ifndef SYNC_BUS_REGS_SVH
`define SYNC_BUS_REGS_SVH
`define NUM_CS 8
`define DIV_W 8
`define WAIT_W 4
// transfer width codes on the bus
`define WIDTH_32 2'h0
`define WIDTH_8 2'h1
`define WIDTH_16 2'h2
`define WIDTH_LINE 2'h3
// chip selects two to seven: upper address byte matches the shared base
`define IO_BASE_HI 31
`define IO_BASE_LO 24
`define IO_BLOCK_HI 23
`define IO_BLOCK_LO 21
`define IO_FIRST_CS 2
// burst geometry
`define LAST_BEAT 2'h3
`define BEAT_STEP 32'h4
`define LINE_SHIFT 32
// reset values
`define RST_DIV 8'h00
`define RST_WAIT 4'h0
`define RST_WORD 32'h0000_0000
`define RST_LINE 128'h0
`define RST_CS 3'h0
`define RST_BEATS 2'h0
`define LANES_NONE 4'hF
`endif
